// >>> acq_ddc.sv
`timescale 1ns/100ps
// Overview of operation
// - input from adc0, adc1, test or loopback
// - memory used as fifo or transient capture
// - gate mode: transfer length follows gate
// - metadata: channel id, timestamp, length
// - 32-bit tuning word, dc to fs
// - decimation programmable from 2 to 131072
// - filter loads user 16-bit coefficients
// - default coefficients form a flat unity kernel
// - complex output 24+24 or 16+16 bits, memory data words always 16+16
// - two 1..256 stages plus fixed 2x
module acq_ddc
    import acq_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // sample sources
    input wire logic [15:0] adc0_data,
    input wire logic [15:0] adc1_data,
    input wire logic [15:0] test_data,
    input wire logic [15:0] loop_data,
    input wire logic acq_gate,
    // output toward memory and dma
    output logic [23:0] out_i,
    output logic [23:0] out_q,
    output logic out_valid,
    input wire logic mem_ready,
    output logic [31:0] mem_data,
    output logic mem_valid,
    output logic mem_meta,
    output logic xfer_done
);
    // ************************************************
    // registers
    // ************************************************
    logic [31:0] ctrl_reg;
    logic [31:0] tune_reg;
    logic [7:0] dec1_reg;
    logic [7:0] dec2_reg;
    logic [31:0] len_reg;
    logic [15:0] coef_mem [COEF_N];
    logic [3:0] coef_ptr_reg;
    logic [31:0] rdata_next;
    logic [31:0] time_reg;
    logic [31:0] count_reg;
    logic [31:0] stamp_reg;
    logic overflow_reg;
    acq_xfer_t state_reg;
    wire w_ctrl = reg_wr && reg_addr == REG_CTRL;
    wire w_coef = reg_wr && reg_addr == REG_COEF;
    wire [1:0] src_sel = ctrl_reg[CTRL_SRC_LSB +: 2];
    wire capture_mode = ctrl_reg[CTRL_MODE_BIT];
    wire gate_mode = ctrl_reg[CTRL_GATE_BIT];
    wire meta_en = ctrl_reg[CTRL_META_BIT];
    wire narrow = ctrl_reg[CTRL_NARROW_BIT];

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ctrl_reg <= CTRL_RST;
            tune_reg <= TUNE_RST;
            dec1_reg <= DEC_RST;
            dec2_reg <= DEC_RST;
            len_reg <= LEN_RST;
            coef_ptr_reg <= 4'h0;
        end
        else if (reg_wr)
        begin
            if (w_ctrl)
                ctrl_reg <= reg_wdata;
            if (reg_addr == REG_TUNE)
                tune_reg <= reg_wdata;
            // register value is ratio minus one: 1..255 gives 2x..256x
            if (reg_addr == REG_DEC1)
                dec1_reg <= reg_wdata[7:0];
            if (reg_addr == REG_DEC2)
                dec2_reg <= reg_wdata[7:0];
            if (reg_addr == REG_LEN)
                len_reg <= reg_wdata;
            if (w_coef)
                coef_ptr_reg <= coef_ptr_reg + 4'h1;
        end
    end

    // coefficient memory: sequential loads, default is a flat unity kernel
    always_ff @(posedge core_clk)
    begin
        for (int k = 0; k < COEF_N; k++)
        begin
            if (rst)
                coef_mem[k] <= COEF_DEF;
            else if (w_coef && coef_ptr_reg == 4'(k))
                coef_mem[k] <= reg_wdata[15:0];
        end
    end

    assign rdata_next = (reg_addr == REG_CTRL) ? ctrl_reg :
                        (reg_addr == REG_TUNE) ? tune_reg :
                        (reg_addr == REG_DEC1) ? {24'h000000, dec1_reg} :
                        (reg_addr == REG_DEC2) ? {24'h000000, dec2_reg} :
                        (reg_addr == REG_STAT) ? {28'h0000000, overflow_reg, state_reg, gate_mode} :
                        (reg_addr == REG_TIME) ? time_reg :
                        (reg_addr == REG_LEN) ? count_reg :
                        32'h0000_0000;

    always_ff @(posedge core_clk)
    begin
        if (rst)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
            reg_rdata <= rdata_next;
    end

    // ************************************************
    // source select and tuning
    // ************************************************
    logic [15:0] samp;
    always_comb
    begin
        unique case (acq_src_t'(src_sel))
            SRC_ADC0: samp = adc0_data;
            SRC_ADC1: samp = adc1_data;
            SRC_TEST: samp = test_data;
            SRC_LOOP: samp = loop_data;
        endcase
    end

    logic [31:0] phase_reg;
    // coarse quadrant mixer: top two phase bits rotate the sample,
    // trading spur level for zero multipliers in the nco
    wire [1:0] quad = phase_reg[31:30];
    wire signed [15:0] s_pos = samp;
    wire signed [15:0] s_neg = -samp;
    wire signed [15:0] mix_i = (quad == 2'b00) ? s_pos : (quad == 2'b10) ? s_neg : 16'sh0000;
    wire signed [15:0] mix_q = (quad == 2'b01) ? s_neg : (quad == 2'b11) ? s_pos : 16'sh0000;
    always_ff @(posedge core_clk)
    begin
        if (rst)
            phase_reg <= 32'h0000_0000;
        else
            phase_reg <= phase_reg + tune_reg;
    end
    always_ff @(posedge core_clk)
    begin
        if (rst)
            time_reg <= 32'h0000_0000;
        else
            time_reg <= time_reg + 32'h0000_0001;
    end

    // ************************************************
    // decimation chain
    // ************************************************
    logic signed [47:0] acc_i_reg;
    logic signed [47:0] acc_q_reg;
    logic [7:0] cnt1_reg;
    logic [7:0] cnt2_reg;
    logic cnt3_reg;
    logic [3:0] tap_reg;
    wire last1 = cnt1_reg == dec1_reg;
    wire last2 = cnt2_reg == dec2_reg;
    wire dump = last1 && last2 && cnt3_reg;
    wire signed [15:0] c = coef_mem[tap_reg];
    wire signed [31:0] p_i = mix_i * c;
    wire signed [31:0] p_q = mix_q * c;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cnt1_reg <= 8'h00;
            cnt2_reg <= 8'h00;
            cnt3_reg <= 1'b0;
            tap_reg <= 4'h0;
            acc_i_reg <= 48'sh0;
            acc_q_reg <= 48'sh0;
        end
        else
        begin
            cnt1_reg <= last1 ? 8'h00 : cnt1_reg + 8'h01;
            if (last1)
            begin
                cnt2_reg <= last2 ? 8'h00 : cnt2_reg + 8'h01;
                if (last2)
                    cnt3_reg <= ~cnt3_reg;
            end
            tap_reg <= tap_reg + 4'h1;
            acc_i_reg <= dump ? 48'(p_i) : acc_i_reg + 48'(p_i);
            acc_q_reg <= dump ? 48'(p_q) : acc_q_reg + 48'(p_q);
        end
    end
    // output format: wide keeps 24 bits, narrow truncates to 16 in the low bits
    wire [23:0] wi = acc_i_reg[47:24];
    wire [23:0] wq = acc_q_reg[47:24];
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            out_i <= 24'h000000;
            out_q <= 24'h000000;
            out_valid <= 1'b0;
        end
        else
        begin
            out_valid <= dump;
            if (dump)
            begin
                out_i <= narrow ? {8'h00, wi[23:8]} : wi;
                out_q <= narrow ? {8'h00, wq[23:8]} : wq;
            end
        end
    end

    // ************************************************
    // memory path and dma packetiser
    // ************************************************
    wire arm = w_ctrl && reg_wdata[CTRL_ARM_BIT];
    wire run = state_reg == XF_RUN;
    // gate mode ends on gate drop, otherwise on programmed length
    wire end_xfer = gate_mode ? !acq_gate : (count_reg >= len_reg);
    logic [1:0] meta_idx_reg;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_reg <= XF_IDLE;
            count_reg <= 32'h0000_0000;
            stamp_reg <= 32'h0000_0000;
            meta_idx_reg <= 2'b00;
            overflow_reg <= 1'b0;
        end
        else
        begin
            if (out_valid && run && !mem_ready)
                overflow_reg <= 1'b1;
            else if (w_ctrl)
                overflow_reg <= 1'b0;
            unique case (state_reg)
                XF_IDLE:
                    if (arm || (!capture_mode && (gate_mode ? acq_gate : 1'b1)))
                    begin
                        if (!gate_mode || acq_gate)
                        begin
                            state_reg <= XF_RUN;
                            count_reg <= 32'h0000_0000;
                            stamp_reg <= time_reg;
                        end
                    end
                XF_RUN:
                    if (end_xfer)
                    begin
                        state_reg <= meta_en ? XF_META : XF_DONE;
                        meta_idx_reg <= 2'b00;
                    end
                    else if (out_valid && mem_ready)
                        count_reg <= count_reg + 32'h0000_0001;
                XF_META:
                    if (mem_ready)
                    begin
                        meta_idx_reg <= meta_idx_reg + 2'b01;
                        if (meta_idx_reg == 2'b10)
                            state_reg <= XF_DONE;
                    end
                XF_DONE:
                    // capture mode is one-shot: waits for a new arm
                    state_reg <= XF_IDLE;
            endcase
        end
    end
    wire [31:0] meta_word = (meta_idx_reg == 2'b00) ? {31'h0, ctrl_reg[CTRL_CHAN_BIT]} :
                            (meta_idx_reg == 2'b01) ? stamp_reg : count_reg;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            mem_data <= 32'h0000_0000;
            mem_valid <= 1'b0;
            mem_meta <= 1'b0;
            xfer_done <= 1'b0;
        end
        else
        begin
            mem_valid <= (run && out_valid && !end_xfer) || (state_reg == XF_META && mem_ready);
            mem_meta <= state_reg == XF_META;
            mem_data <= (state_reg == XF_META) ? meta_word :
                        narrow ? {out_i[15:0], out_q[15:0]} : {out_i[23:8], out_q[23:8]};
            xfer_done <= state_reg == XF_DONE;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    a_valid_pulse: assert property (@(posedge core_clk) disable iff (rst)
        out_valid |=> !out_valid) else $error("valid longer than one cycle");
    a_src_adc0: assert property (@(posedge core_clk) disable iff (rst)
        src_sel == 2'b00 |-> samp == adc0_data) else $error("source select wrong");
    a_src_loop: assert property (@(posedge core_clk) disable iff (rst)
        src_sel == 2'b11 |-> samp == loop_data) else $error("loopback select wrong");
    a_tune_step: assert property (@(posedge core_clk) disable iff (rst)
        $stable(tune_reg) |=> phase_reg == $past(phase_reg) + $past(tune_reg)) else $error("nco step wrong");
    a_dump_cause: assert property (@(posedge core_clk) disable iff (rst)
        out_valid |-> $past(cnt3_reg) && $past(last1) && $past(last2)) else $error("dump not at chain end");
    a_gate_end: assert property (@(posedge core_clk) disable iff (rst)
        run && gate_mode && !acq_gate |=> state_reg != XF_RUN) else $error("gate drop not ending transfer");
    a_meta_stamp: assert property (@(posedge core_clk) disable iff (rst)
        state_reg == XF_IDLE ##1 state_reg == XF_RUN |-> stamp_reg == $past(time_reg)) else $error("stamp wrong");
    a_narrow_fmt: assert property (@(posedge core_clk) disable iff (rst)
        out_valid && narrow && $stable(narrow) |-> out_i[23:16] == 8'h00) else $error("narrow format wrong");
    a_coef_load: assert property (@(posedge core_clk) disable iff (rst)
        w_coef |=> coef_mem[$past(coef_ptr_reg)] == 16'($past(reg_wdata))) else $error("coef not loaded");
    a_capture_once: assert property (@(posedge core_clk) disable iff (rst)
        state_reg == XF_IDLE && capture_mode && !arm |=> state_reg == XF_IDLE) else $error("capture rearmed");
endmodule : acq_ddc

// >>> acq_mem_model.sv
`timescale 1ns/100ps
// ****
// memory side model
// ****
module acq_mem_model
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // stream from the block
    input wire logic [31:0] mem_data,
    input wire logic mem_valid,
    input wire logic mem_meta,
    // bench control: 0 prompt, 1 random stalls, 2 held off
    input wire logic [1:0] mode,
    input wire logic clr,
    // flow control
    output logic mem_ready
);
    int data_cnt;
    int meta_cnt;
    logic [31:0] meta_word [0:3];
    initial mem_ready = 1'b0;
    // no buffer here, so a stall is seen at once by the block
    always @(posedge core_clk)
    begin
        mem_ready <= (mode == 2'h0) || (mode == 2'h1 && $urandom % 2 == 0);
        if (rst || clr)
        begin
            data_cnt <= 0;
            meta_cnt <= 0;
        end
        else if (mem_valid && mem_meta)
        begin
            meta_word[meta_cnt % 4] <= mem_data;
            meta_cnt <= meta_cnt + 1;
        end
        else if (mem_valid)
            data_cnt <= data_cnt + 1;
    end
endmodule : acq_mem_model

// >>> acq_pkg.sv
package acq_pkg;
    // register indices (word addresses on the plain port)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_TUNE = 4'h1;
    localparam logic [3:0] REG_DEC1 = 4'h2;
    localparam logic [3:0] REG_DEC2 = 4'h3;
    localparam logic [3:0] REG_COEF = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h5;
    localparam logic [3:0] REG_TIME = 4'h6;
    localparam logic [3:0] REG_LEN = 4'h7;
    // control fields
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_MODE_BIT = 2;
    localparam int CTRL_GATE_BIT = 3;
    localparam int CTRL_META_BIT = 4;
    localparam int CTRL_NARROW_BIT = 5;
    localparam int CTRL_ARM_BIT = 6;
    localparam int CTRL_CHAN_BIT = 7;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] TUNE_RST = 32'h0000_0000;
    localparam logic [7:0] DEC_RST = 8'h01;
    localparam int COEF_N = 16;
    localparam logic [15:0] COEF_DEF = 16'h0800;
    localparam logic [31:0] LEN_RST = 32'h0000_0400;
    typedef enum logic [1:0] {
        SRC_ADC0 = 2'b00,
        SRC_ADC1 = 2'b01,
        SRC_TEST = 2'b10,
        SRC_LOOP = 2'b11
    } acq_src_t;
    typedef enum logic [1:0] {
        XF_IDLE = 2'b00,
        XF_RUN = 2'b01,
        XF_META = 2'b10,
        XF_DONE = 2'b11
    } acq_xfer_t;
endpackage : acq_pkg

// >>> tb.sv
`timescale 1ns/100ps
// ****
// bench
// ****
module tb;
    import acq_pkg::*;
    logic core_clk, rst, reg_wr, reg_rd, acq_gate, clr, rnd_on, out_valid, mem_ready, mem_valid, mem_meta, xfer_done;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, mem_data, rv;
    logic [15:0] smp [0:3];
    logic [23:0] out_i, out_q;
    logic [1:0] mode;
    int fail_count, tests_run, n, d1, d2;
    acq_ddc DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc0_data(smp[0]), .adc1_data(smp[1]), .test_data(smp[2]),
        .loop_data(smp[3]), .acq_gate(acq_gate), .out_i(out_i), .out_q(out_q), .out_valid(out_valid),
        .mem_ready(mem_ready), .mem_data(mem_data), .mem_valid(mem_valid), .mem_meta(mem_meta), .xfer_done(xfer_done));
    acq_mem_model mem (.core_clk(core_clk), .rst(rst), .mem_data(mem_data), .mem_valid(mem_valid),
        .mem_meta(mem_meta), .mode(mode), .clr(clr), .mem_ready(mem_ready));
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
        if (rnd_on)
            for (int j = 0; j < 4; j++)
                smp[j] <= 16'($urandom);
    function automatic logic [31:0] dec_total(input int a, input int b);
        return 32'((a + 1) * (b + 1) * 2);
    endfunction : dec_total
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask : rd
    // n ends as the edge count between the last two pulses
    task wait_v(input int cnt);
        int k;
        repeat (cnt)
        begin
            k = 0;
            @(posedge core_clk);
            #1;
            while (out_valid !== 1'b1 && k < 3000)
            begin
                @(posedge core_clk);
                #1;
                k++;
            end
            n = k + 1;
        end
    endtask : wait_v
    task wait_done;
        n = 0;
        while (xfer_done !== 1'b1 && n < 3000)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("xfer_done", {31'h0, n < 3000}, 32'h1);
    endtask : wait_done
    task restart(input logic [1:0] m);
        @(posedge core_clk);
        clr <= 1'b1;
        mode <= m;
        @(posedge core_clk);
        clr <= 1'b0;
    endtask : restart
    task close_out;
        $display("tests run %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (60000) @(posedge core_clk);
        fail_count++;
        close_out;
    end
    initial
    begin
        void'($urandom(50975));
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata, acq_gate, clr, rnd_on, mode} = {1'b1, 43'h0};
        {fail_count, tests_run} = 0;
        for (int j = 0; j < 4; j++)
            smp[j] = 16'h0000;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        // ****
        // registers
        // ****
        rd(REG_CTRL); chk("ctrl rst", rv, CTRL_RST);
        rd(REG_TUNE); chk("tune rst", rv, TUNE_RST);
        rd(REG_DEC1); chk("dec1 rst", rv, {24'h0, DEC_RST});
        rd(REG_DEC2); chk("dec2 rst", rv, {24'h0, DEC_RST});
        // length index reads the live count: the fifo stream after reset has taken one sample
        rd(REG_LEN); chk("count early", rv, 32'h1);
        rd(4'hF); chk("unmapped", rv, 32'h0);
        for (int j = 0; j < 2; j++)
        begin
            d1 = j ? 32'hFFFF_FFFF : $urandom;
            wr(REG_TUNE, 32'(d1)); rd(REG_TUNE); chk("tune", rv, 32'(d1));
        end
        wr(REG_TUNE, 32'h0);
        wr(REG_DEC1, 32'h0000_00FF); rd(REG_DEC1); chk("dec max", rv, 32'h0000_00FF);
        $display("register test done");
        // ****
        // decimation spacing
        // ****
        for (int k = 0; k < 3; k++)
        begin
            d1 = (k == 0) ? 1 : 1 + $urandom % 3;
            d2 = (k == 0) ? 1 : 1 + $urandom % 3;
            wr(REG_DEC1, 32'(d1)); wr(REG_DEC2, 32'(d2)); wait_v(3);
            chk("period", 32'(n), dec_total(d1, d2));
            @(posedge core_clk); #1;
            chk("pulse", {31'h0, out_valid}, 32'h0);
        end
        wr(REG_DEC1, 32'h1); wr(REG_DEC2, 32'h1);
        $display("decimation test done");
        // ****
        // source select, constant input
        // ****
        for (int s = 0; s < 4; s++)
        begin
            wr(REG_CTRL, 32'(s));
            for (int j = 0; j < 4; j++)
                smp[j] <= (j == s) ? 16'h1000 : 16'h0000;
            wait_v(20); chk("src on", {31'h0, (out_i | out_q) != 24'h0}, 32'h1);
            for (int j = 0; j < 4; j++)
                smp[j] <= (j == s) ? 16'h0000 : 16'h1000;
            wait_v(20); chk("src off", {out_i[15:0], out_q[15:0]}, 32'h0);
        end
        $display("source test done");
        rnd_on <= 1'b1;
        wr(REG_CTRL, 32'h1 << CTRL_NARROW_BIT);
        // the first pulse after the write already carries the narrow format, but is left unchecked
        wait_v(1);
        repeat (4)
        begin
            wait_v(1); chk("narrow", {16'h0, out_i[23:16], out_q[23:16]}, 32'h0);
        end
        $display("narrow test done");
        // ****
        // transfers toward memory
        // ****
        // stop the free-running stream first, an arm is lost outside idle
        wr(REG_LEN, 32'h4);
        wr(REG_CTRL, 32'h1 << CTRL_MODE_BIT);
        repeat (64) @(posedge core_clk);
        restart(2'h0);
        wr(REG_CTRL, (32'h1 << CTRL_ARM_BIT) | (32'h1 << CTRL_MODE_BIT) | (32'h1 << CTRL_META_BIT) | 32'h80);
        wait_done;
        chk("capture words", 32'(mem.data_cnt), 32'h4);
        chk("meta words", 32'(mem.meta_cnt), 32'h3);
        chk("meta chan", mem.meta_word[0], 32'h1);
        chk("meta len", mem.meta_word[2], 32'h4);
        restart(2'h1);
        wr(REG_LEN, 32'h2);
        wr(REG_CTRL, 32'h1 << CTRL_GATE_BIT);
        acq_gate <= 1'b1;
        wait_v(10);
        @(posedge core_clk);
        acq_gate <= 1'b0;
        wait_done;
        chk("gate words", 32'(mem.data_cnt), 32'hA);
        chk("gate meta", 32'(mem.meta_cnt), 32'h0);
        rd(REG_STAT); chk("gate flag", {31'h0, rv[0]}, 32'h1);
        restart(2'h2);
        // arm sees the old gate mode, so leave gate mode before arming
        wr(REG_CTRL, 32'h1 << CTRL_MODE_BIT);
        wr(REG_CTRL, (32'h1 << CTRL_ARM_BIT) | (32'h1 << CTRL_MODE_BIT));
        wait_v(2);
        // release memory so the held capture can finish
        restart(2'h0);
        wait_done;
        rd(REG_STAT); chk("overflow", {31'h0, rv[3]}, 32'h1);
        restart(2'h0);
        wr(REG_CTRL, 32'h0);
        rd(REG_STAT); chk("overflow clr", {31'h0, rv[3]}, 32'h0);
        $display("transfer test done");
        // ****
        // user coefficients
        // ****
        repeat (COEF_N) wr(REG_COEF, 32'h0);
        wait_v(20); chk("zero taps", {out_i[15:0], out_q[15:0]}, 32'h0);
        $display("coefficient test done");
        close_out;
    end
endmodule : tb
